// ===== rtl/oscd_map.vh
// Purpose: Constants for the crystal-loss and stop-exit host controller
// Assumes: APB byte addresses, 32-bit data, 20 MHz clock
// Notes:   Included by the controller top and nothing else
//
// What this block does
// - Host sets wake levels, others 000b, enables
// - Host keeps detection off at 2 MHz or less
// - Source identified from flags and enable field
// - Host switches clock back to crystal itself
// - Host clears peripheral stop before wait when detection is on, else copies the config bit
// - Host disables detection before crystal stop/start
// - Low-speed fallback: select low, then enable
// - High-speed fallback: enable and select together, then enable detection
// - Flash rewrite off, stop, jump, 4 NOPs
// - Flash rewrite off, wait, 4 NOPs
// - Host writes 00b to field before stop
`ifndef OSCD_MAP_VH
`define OSCD_MAP_VH

// Register byte offsets
`define OSCD_CTRL_OFS      12'h000
`define OSCD_CFG_OFS       12'h004
`define OSCD_STATUS_OFS    12'h008
`define OSCD_PINS_OFS      12'h00c

// Command bits in the control register
`define OSCD_CMD_STOP      0
`define OSCD_CMD_WAIT      1
`define OSCD_CMD_ARM       2
`define OSCD_CMD_FB_LOW    3
`define OSCD_CMD_FB_HIGH   4
`define OSCD_CMD_XSTOP     5
`define OSCD_CMD_XSTART    6
`define OSCD_CMD_BACK      7
`define OSCD_CMD_W         8

// Configuration fields
`define OSCD_CFG_SLOW      0
`define OSCD_CFG_LVL_LO    1
`define OSCD_CFG_LVL_HI    3
`define OSCD_CFG_PSTOP     4
`define OSCD_CFG_FLASH     5
`define OSCD_CFG_RESET     6'h00

// Status fields
`define OSCD_ST_BUSY       0
`define OSCD_ST_REFUSED    1
`define OSCD_ST_NMI_SEEN   2
`define OSCD_ST_SRC_LO     3
`define OSCD_ST_SRC_HI     6
`define OSCD_ST_LIVE_LO    7
`define OSCD_ST_LIVE_HI    10
`define OSCD_ST_ONCHIP     11
`define OSCD_ST_XSTOPPED   12

// Detection enable field and priority level values
`define OSCD_DET_ON        2'h3
`define OSCD_DET_OFF       2'h0
`define OSCD_LVL_OFF       3'h0

// Padding after stop or wait
`define OSCD_PAD_NOPS      3'h4

`endif

// ===== rtl/oscd_sync.v
// Purpose: Two-flop synchroniser for a group of device flag pins
// Assumes: Each bit is an independent level
// Notes:   First flop feeds only the second flop
`timescale 1ns/1ns
module oscd_sync #(
  parameter W = 6
) (
  // Clock and reset
  input  wire         clock_i,
  input  wire         reset_i,
  // Levels
  input  wire [W-1:0] async_i,
  output wire [W-1:0] sync_o
);

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      reg meta_r;
      reg sync_r;
      always @(posedge clock_i) begin
        if (reset_i) begin
          meta_r <= 1'b0;
          sync_r <= 1'b0;
        end else begin
          meta_r <= async_i[g];
          sync_r <= meta_r;
        end
      end
      assign sync_o[g] = sync_r;
    end
  endgenerate

endmodule

// ===== rtl/oscd_ctrl.v
// Purpose: Host sequencer driving the clock-control pins of the device
// Assumes: Device flags arrive asynchronously; APB master on clock_i
// Notes:   One command at a time; commands written while busy are refused
//
// The placing of the registers and the APB slave port were decided locally.
`timescale 1ns/1ns
`include "oscd_map.vh"
module oscd_ctrl (
  // Clock and reset
  input  wire        clock_i,
  input  wire        reset_i,
  // APB slave
  input  wire        psel_i,
  input  wire        penable_i,
  input  wire        pwrite_i,
  input  wire [11:0] paddr_i,
  input  wire [31:0] pwdata_i,
  output wire        pready_o,
  output reg  [31:0] prdata_o,
  output reg         pslverr_o,
  // Device status pins
  input  wire        onchip_clock_selected_flag_i,
  input  wire        xtal_stopped_flag_i,
  input  wire        special_nmi_i,
  input  wire        watchdog_event_flag_i,
  input  wire        vmon_one_detect_flag_i,
  input  wire        vmon_two_detect_flag_i,
  // Device control pins
  output reg  [1:0]  xtal_loss_detect_enable_field_o,
  output reg         all_clock_stop_request_o,
  output reg         wait_exec_o,
  output reg         jump_exec_o,
  output reg         nop_exec_o,
  output reg         xtal_stop_control_o,
  output reg         periph_clock_stop_in_wait_o,
  output reg  [2:0]  wake_irq_priority_level_o,
  output reg  [2:0]  other_irq_priority_level_o,
  output reg         global_irq_enable_o,
  output reg         wake_periph_start_o,
  output reg         cpu_flash_rewrite_enable_o,
  output reg         high_speed_osc_enable_o,
  output reg         onchip_osc_speed_select_o,
  output reg         clock_source_xtal_o
);

  localparam [6:0] S_IDLE   = 7'h01;
  localparam [6:0] S_DISARM = 7'h02;
  localparam [6:0] S_PREP   = 7'h04;
  localparam [6:0] S_ISSUE  = 7'h08;
  localparam [6:0] S_JUMP   = 7'h10;
  localparam [6:0] S_PAD    = 7'h20;
  localparam [6:0] S_ARM    = 7'h40;

  reg  [6:0]             state_r;
  reg  [`OSCD_CMD_W-1:0] cmd_r;
  reg  [2:0]             pad_cnt_r;
  reg  [5:0]             cfg_r;
  reg                    refused_r;
  reg                    nmi_seen_r;
  reg  [3:0]             src_r;
  reg                    nmi_d_r;

  wire [5:0]             flags_s;
  wire                   onchip_s;
  wire                   xstopped_s;
  wire                   nmi_s;
  wire                   wdt_s;
  wire                   vm1_s;
  wire                   vm2_s;

  oscd_sync #(
    .W (6)
  ) u_sync (
    .clock_i (clock_i),
    .reset_i (reset_i),
    .async_i ({vmon_two_detect_flag_i, vmon_one_detect_flag_i, watchdog_event_flag_i,
               special_nmi_i, xtal_stopped_flag_i, onchip_clock_selected_flag_i}),
    .sync_o  (flags_s)
  );

  assign onchip_s   = flags_s[0];
  assign xstopped_s = flags_s[1];
  assign nmi_s      = flags_s[2];
  assign wdt_s      = flags_s[3];
  assign vm1_s      = flags_s[4];
  assign vm2_s      = flags_s[5];

  // One vector serves four causes, so the cause is decoded from flags
  wire det_on   = (xtal_loss_detect_enable_field_o == `OSCD_DET_ON);
  wire xtal_src = xstopped_s | (det_on & onchip_s);
  wire [3:0] live_src = {vm2_s, vm1_s, wdt_s, xtal_src};

  // APB decode
  wire setup_ph = psel_i & ~penable_i;
  wire wr_en    = psel_i & penable_i & pwrite_i;
  wire ofs_ok   = (paddr_i == `OSCD_CTRL_OFS) | (paddr_i == `OSCD_CFG_OFS) |
                  (paddr_i == `OSCD_STATUS_OFS) | (paddr_i == `OSCD_PINS_OFS);
  wire wr_ctrl  = wr_en & (paddr_i == `OSCD_CTRL_OFS);
  wire wr_cfg   = wr_en & (paddr_i == `OSCD_CFG_OFS);
  wire wr_stat  = wr_en & (paddr_i == `OSCD_STATUS_OFS);

  // Answer always in the first access cycle
  assign pready_o = psel_i & penable_i;

  wire [`OSCD_CMD_W-1:0] cmd_w   = pwdata_i[`OSCD_CMD_W-1:0];
  wire                   one_hot = (cmd_w != 8'h00) & ((cmd_w & (cmd_w - 8'h01)) == 8'h00);
  wire [2:0]             cfg_lvl = cfg_r[`OSCD_CFG_LVL_HI:`OSCD_CFG_LVL_LO];
  wire                   slow    = cfg_r[`OSCD_CFG_SLOW];
  // Stop with no wake level could never exit except by reset
  wire                   lvl_bad = cmd_w[`OSCD_CMD_STOP] & (cfg_lvl == `OSCD_LVL_OFF);
  // Arming is pointless below the detector's frequency floor
  wire                   arm_bad = slow & (cmd_w[`OSCD_CMD_ARM] | cmd_w[`OSCD_CMD_FB_LOW] |
                                           cmd_w[`OSCD_CMD_FB_HIGH]);
  wire                   accept  = wr_ctrl & (state_r == S_IDLE) & one_hot & ~lvl_bad & ~arm_bad;
  wire                   reject  = wr_ctrl & ~accept & (cmd_w != 8'h00);

  reg [6:0] first_state;
  always @* begin
    if (cmd_w[`OSCD_CMD_STOP] | cmd_w[`OSCD_CMD_XSTOP] | cmd_w[`OSCD_CMD_XSTART]) begin
      first_state = S_DISARM;
    end else if (cmd_w[`OSCD_CMD_ARM]) begin
      first_state = S_ARM;
    end else if (cmd_w[`OSCD_CMD_BACK]) begin
      first_state = S_ISSUE;
    end else begin
      first_state = S_PREP;
    end
  end

  // Register reads are captured in the setup cycle
  always @(posedge clock_i) begin
    if (reset_i) begin
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else if (setup_ph) begin
      pslverr_o <= ~ofs_ok;
      case (paddr_i)
        `OSCD_CFG_OFS: begin
          prdata_o <= {26'h0, cfg_r};
        end
        `OSCD_STATUS_OFS: begin
          prdata_o <= {19'h0, xstopped_s, onchip_s, live_src, src_r, nmi_seen_r, refused_r,
                       (state_r != S_IDLE)};
        end
        `OSCD_PINS_OFS: begin
          prdata_o <= {16'h0, clock_source_xtal_o, onchip_osc_speed_select_o,
                       high_speed_osc_enable_o, cpu_flash_rewrite_enable_o,
                       wake_periph_start_o, global_irq_enable_o, other_irq_priority_level_o,
                       wake_irq_priority_level_o, periph_clock_stop_in_wait_o,
                       xtal_stop_control_o, xtal_loss_detect_enable_field_o};
        end
        default: begin
          prdata_o <= 32'h0000_0000;
        end
      endcase
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  always @(posedge clock_i) begin
    if (reset_i) begin
      refused_r  <= 1'b0;
      nmi_seen_r <= 1'b0;
      src_r      <= 4'h0;
      nmi_d_r    <= 1'b0;
    end else begin
      nmi_d_r <= nmi_s;
      if (reject) begin
        refused_r <= 1'b1;
      end else if (wr_stat & pwdata_i[`OSCD_ST_REFUSED]) begin
        refused_r <= 1'b0;
      end
      if (nmi_s & ~nmi_d_r) begin
        nmi_seen_r <= 1'b1;
        src_r      <= live_src;
      end else if (wr_stat & pwdata_i[`OSCD_ST_NMI_SEEN]) begin
        nmi_seen_r <= 1'b0;
      end
    end
  end

  // Command sequencer
  always @(posedge clock_i) begin
    if (reset_i) begin
      state_r                         <= S_IDLE;
      cmd_r                           <= 8'h00;
      pad_cnt_r                       <= 3'h0;
      cfg_r                           <= `OSCD_CFG_RESET;
      xtal_loss_detect_enable_field_o <= `OSCD_DET_OFF;
      all_clock_stop_request_o        <= 1'b0;
      wait_exec_o                     <= 1'b0;
      jump_exec_o                     <= 1'b0;
      nop_exec_o                      <= 1'b0;
      xtal_stop_control_o             <= 1'b0;
      periph_clock_stop_in_wait_o     <= 1'b0;
      wake_irq_priority_level_o       <= `OSCD_LVL_OFF;
      other_irq_priority_level_o      <= `OSCD_LVL_OFF;
      global_irq_enable_o             <= 1'b0;
      wake_periph_start_o             <= 1'b0;
      cpu_flash_rewrite_enable_o      <= 1'b0;
      high_speed_osc_enable_o         <= 1'b0;
      onchip_osc_speed_select_o       <= 1'b0;
      clock_source_xtal_o             <= 1'b0;
    end else begin
      all_clock_stop_request_o <= 1'b0;
      wait_exec_o              <= 1'b0;
      jump_exec_o              <= 1'b0;
      nop_exec_o               <= 1'b0;
      clock_source_xtal_o      <= 1'b0;
      if (wr_cfg) begin
        cfg_r <= pwdata_i[5:0];
      end
      // A slow crystal setting forces detection off at once
      if (slow) begin
        xtal_loss_detect_enable_field_o <= `OSCD_DET_OFF;
      end
      case (state_r)
        S_IDLE: begin
          if (wr_cfg & (state_r == S_IDLE)) begin
            cpu_flash_rewrite_enable_o <= pwdata_i[`OSCD_CFG_FLASH];
          end
          if (accept) begin
            cmd_r   <= cmd_w;
            state_r <= first_state;
          end
        end
        S_DISARM: begin
          xtal_loss_detect_enable_field_o <= `OSCD_DET_OFF;
          state_r                         <= S_PREP;
        end
        S_PREP: begin
          state_r <= S_ISSUE;
          if (cmd_r[`OSCD_CMD_STOP]) begin
            cpu_flash_rewrite_enable_o <= 1'b0;
            wake_irq_priority_level_o  <= cfg_lvl;
            other_irq_priority_level_o <= `OSCD_LVL_OFF;
            global_irq_enable_o        <= 1'b1;
            wake_periph_start_o        <= 1'b1;
          end else if (cmd_r[`OSCD_CMD_WAIT]) begin
            cpu_flash_rewrite_enable_o  <= 1'b0;
            periph_clock_stop_in_wait_o <= det_on ? 1'b0 : cfg_r[`OSCD_CFG_PSTOP];
          end else if (cmd_r[`OSCD_CMD_FB_LOW]) begin
            onchip_osc_speed_select_o <= 1'b0;
            state_r                   <= S_ARM;
          end else if (cmd_r[`OSCD_CMD_FB_HIGH]) begin
            high_speed_osc_enable_o   <= 1'b1;
            onchip_osc_speed_select_o <= 1'b1;
            state_r                   <= S_ARM;
          end
        end
        S_ISSUE: begin
          state_r <= S_IDLE;
          if (cmd_r[`OSCD_CMD_STOP]) begin
            // Device also goes to divide-by-8 and high drive here
            all_clock_stop_request_o <= 1'b1;
            state_r                  <= S_JUMP;
          end else if (cmd_r[`OSCD_CMD_WAIT]) begin
            wait_exec_o <= 1'b1;
            pad_cnt_r   <= 3'h0;
            state_r     <= S_PAD;
          end else if (cmd_r[`OSCD_CMD_XSTOP]) begin
            xtal_stop_control_o <= 1'b1;
          end else if (cmd_r[`OSCD_CMD_XSTART]) begin
            xtal_stop_control_o <= 1'b0;
          end else if (cmd_r[`OSCD_CMD_BACK]) begin
            // Device never returns to the crystal on its own
            clock_source_xtal_o <= 1'b1;
          end
        end
        S_JUMP: begin
          jump_exec_o <= 1'b1;
          pad_cnt_r   <= 3'h0;
          state_r     <= S_PAD;
        end
        S_PAD: begin
          // Covers the device's 4-byte prefetch past the halting write
          nop_exec_o <= 1'b1;
          pad_cnt_r  <= pad_cnt_r + 3'h1;
          if (pad_cnt_r == (`OSCD_PAD_NOPS - 3'h1)) begin
            state_r <= S_IDLE;
          end
        end
        S_ARM: begin
          // Only 11b arms the detector; loss window is the device's
          if (!slow) begin
            xtal_loss_detect_enable_field_o <= `OSCD_DET_ON;
          end
          state_r <= S_IDLE;
        end
        default: begin
          state_r <= S_IDLE;
        end
      endcase
    end
  end

endmodule

// ===== testbench/oscd_properties.sv
// Purpose: Port checker for oscd_ctrl
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to every oscd_ctrl instance
`timescale 1ns/1ns
module oscd_properties (
  // Clock, reset and APB
  input wire        clock_i,
  input wire        reset_i,
  input wire        psel_i,
  input wire        penable_i,
  input wire        pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  // Device control pins
  input wire [1:0]  xtal_loss_detect_enable_field_o,
  input wire        all_clock_stop_request_o,
  input wire        wait_exec_o,
  input wire        jump_exec_o,
  input wire        nop_exec_o,
  input wire        xtal_stop_control_o,
  input wire        periph_clock_stop_in_wait_o,
  input wire [2:0]  wake_irq_priority_level_o,
  input wire        global_irq_enable_o,
  input wire        cpu_flash_rewrite_enable_o,
  input wire        high_speed_osc_enable_o,
  input wire        onchip_osc_speed_select_o,
  input wire        clock_source_xtal_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (reset_i);
  wire [1:0] fld = xtal_loss_detect_enable_field_o;
  wire       wr  = psel_i & penable_i & pwrite_i;
  reg        slow_r;
  reg        back_r;
  // Shadow of the slow-crystal wish and of BACK writes
  always @(posedge clock_i) begin
    if (reset_i) begin
      slow_r <= 1'b0;
      back_r <= 1'b0;
    end else begin
      if (wr && paddr_i == 12'h004)
        slow_r <= pwdata_i[0];
      back_r <= wr && paddr_i == 12'h000 && pwdata_i == 32'h80;
    end
  end
  sequence s_pad;
    nop_exec_o [*4] ##1 !nop_exec_o;
  endsequence
  sequence s_jmp;
    jump_exec_o && !nop_exec_o;
  endsequence
  property p_stop_ctx;
    all_clock_stop_request_o |-> fld == 2'h0 && !cpu_flash_rewrite_enable_o &&
      global_irq_enable_o && wake_irq_priority_level_o != 3'h0;
  endproperty
  property p_stop_seq;
    all_clock_stop_request_o |=> s_jmp ##1 s_pad;
  endproperty
  property p_wait_seq;
    wait_exec_o |-> !cpu_flash_rewrite_enable_o ##1 s_pad;
  endproperty
  property p_wait_pstop;
    wait_exec_o && fld == 2'h3 |-> !periph_clock_stop_in_wait_o;
  endproperty
  property p_xstop;
    $changed(xtal_stop_control_o) |-> fld == 2'h0 && $past(fld) == 2'h0;
  endproperty
  property p_slow;
    $past(slow_r) |-> fld == 2'h0;
  endproperty
  property p_hs;
    $rose(fld == 2'h3) && onchip_osc_speed_select_o |->
      high_speed_osc_enable_o && $past(onchip_osc_speed_select_o);
  endproperty
  property p_back;
    clock_source_xtal_o |-> back_r || $past(back_r);
  endproperty
  a_stop_ctx: assert property (p_stop_ctx) else $error("stop without setup");
  a_stop_seq: assert property (p_stop_seq) else $error("stop padding wrong");
  a_wait_seq: assert property (p_wait_seq) else $error("wait padding wrong");
  a_wait_pstop: assert property (p_wait_pstop) else $error("pstop set in wait");
  a_xstop: assert property (p_xstop) else $error("crystal toggled armed");
  a_slow: assert property (p_slow) else $error("armed on slow crystal");
  a_hs: assert property (p_hs) else $error("fast fallback order");
  a_back: assert property (p_back) else $error("switch back uncommanded");
endmodule
bind oscd_ctrl oscd_properties oscd_properties_inst (.*);

// ===== testbench/oscd_device_model.sv
// Purpose: Behavioural device with crystal-loss detect and stop mode
// Assumes: Flags are plain levels toward the controller
// Notes:   Loss window is short; the bench owns crystal and sources
`timescale 1ns/1ns
module oscd_device_model #(
  parameter LOSS_WIN = 4
) (
  // Clock and reset
  input  wire       clock_i,
  input  wire       reset_i,
  // From the controller
  input  wire [1:0] field_i,
  input  wire       stop_i,
  input  wire       wait_i,
  input  wire       nop_i,
  input  wire       xstop_i,
  input  wire       back_i,
  // From the bench
  input  wire       xtal_ok_i,
  input  wire [2:0] src_i,
  input  wire       wake_i,
  // Flags and observation
  output reg        onchip_o,
  output reg        xstopped_o,
  output wire       nmi_o,
  output reg        stopped_o,
  output reg        div8_o,
  output reg  [3:0] nops_o
);
  reg  [3:0] miss_r;
  reg        on_xtal_r;
  wire       run = xtal_ok_i & ~xstop_i;
  // One vector for all four sources
  assign nmi_o = xstopped_o | (field_i == 2'h3 & onchip_o) | (|src_i);
  always @(posedge clock_i) begin
    if (reset_i) begin
      miss_r     <= 4'h0;
      on_xtal_r  <= 1'b1;
      onchip_o   <= 1'b0;
      xstopped_o <= 1'b0;
      stopped_o  <= 1'b0;
      div8_o     <= 1'b0;
      nops_o     <= 4'h0;
    end else begin
      miss_r <= (run || field_i != 2'h3) ? 4'h0 : miss_r + 4'h1;
      if (on_xtal_r && miss_r == LOSS_WIN) begin
        onchip_o   <= 1'b1;
        xstopped_o <= 1'b1;
        on_xtal_r  <= 1'b0;
      end
      // Never returns to the crystal on its own
      if (back_i && run) begin
        onchip_o   <= 1'b0;
        xstopped_o <= 1'b0;
        on_xtal_r  <= 1'b1;
      end
      if (stop_i) begin
        stopped_o <= 1'b1;
        div8_o    <= 1'b1;
      end else if (wake_i) begin
        stopped_o <= 1'b0;
      end
      if (stop_i | wait_i)
        nops_o <= 4'h0;
      else if (nop_i)
        nops_o <= nops_o + 4'h1;
    end
  end
endmodule

// ===== testbench/oscd_ctrl_tb_top.sv
// Purpose: Self-checking bench for oscd_ctrl with a device model
// Assumes: APB master drives on rising edges by non-blocking assignment
// Notes:   Busy is polled through STATUS instead of fixed delays
`timescale 1ns/1ns
module oscd_ctrl_tb_top;
  typedef struct packed {
    logic        w;
    logic [11:0] a;
    logic [31:0] d;
    logic [31:0] x;
    logic        e;
  } oscd_row_t;
  reg         clock_i = 1'b0;
  reg         reset_i = 1'b1;
  reg         psel_i = 1'b0;
  reg         penable_i = 1'b0;
  reg         pwrite_i = 1'b0;
  reg  [11:0] paddr_i = 12'h000;
  reg  [31:0] pwdata_i = 32'h0;
  reg         xtal_ok = 1'b1;
  reg  [2:0]  src = 3'h0;
  reg         wake = 1'b0;
  wire        pready_o, pslverr_o, onchip, xstopped, nmi, stopped, div8;
  wire        stop, waitx, nop, xstop, back;
  wire [31:0] prdata_o;
  wire [1:0]  field;
  wire [3:0]  nops;
  int         num_errors = 0;
  int         total_checks = 0;
  logic [31:0] q;
  logic        e;
  oscd_row_t   rows [7];
  always #25 clock_i = ~clock_i;
  oscd_ctrl oscd_ctrl_inst (
    .clock_i(clock_i), .reset_i(reset_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .prdata_o(prdata_o), .pslverr_o(pslverr_o), .onchip_clock_selected_flag_i(onchip),
    .xtal_stopped_flag_i(xstopped), .special_nmi_i(nmi), .watchdog_event_flag_i(src[0]),
    .vmon_one_detect_flag_i(src[1]), .vmon_two_detect_flag_i(src[2]),
    .xtal_loss_detect_enable_field_o(field), .all_clock_stop_request_o(stop),
    .wait_exec_o(waitx), .jump_exec_o(), .nop_exec_o(nop), .xtal_stop_control_o(xstop),
    .periph_clock_stop_in_wait_o(), .wake_irq_priority_level_o(),
    .other_irq_priority_level_o(), .global_irq_enable_o(), .wake_periph_start_o(),
    .cpu_flash_rewrite_enable_o(), .high_speed_osc_enable_o(),
    .onchip_osc_speed_select_o(), .clock_source_xtal_o(back));
  oscd_device_model oscd_device_model_inst (
    .clock_i(clock_i), .reset_i(reset_i), .field_i(field), .stop_i(stop), .wait_i(waitx),
    .nop_i(nop), .xstop_i(xstop), .back_i(back), .xtal_ok_i(xtal_ok), .src_i(src),
    .wake_i(wake), .onchip_o(onchip), .xstopped_o(xstopped), .nmi_o(nmi),
    .stopped_o(stopped), .div8_o(div8), .nops_o(nops));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Idle cycle after release keeps psel from being driven twice per step
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clock_i);
    penable_i <= 1'b1;
    @(posedge clock_i);
    while (pready_o !== 1'b1) @(posedge clock_i);
    q = prdata_o;
    e = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
    @(posedge clock_i);
  endtask
  task cmd(input logic [31:0] d);
    apb(1'b1, 12'h000, d);
    do apb(1'b0, 12'h008, 32'h0); while (q[0] !== 1'b0);
  endtask
  task look(input logic [11:0] a, input logic [31:0] m, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(q & m, x);
  endtask
  task wait_nmi;
    do apb(1'b0, 12'h008, 32'h0); while (q[2] !== 1'b1);
  endtask
  task give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    give_verdict;
  end
  initial begin
    rows = '{'{1, 12'h004, 32'h0a, 32'h0, 0}, '{0, 12'h004, 32'h0, 32'h0a, 0},
             '{0, 12'h000, 32'h0, 32'h0, 0}, '{0, 12'h010, 32'h0, 32'h0, 1},
             '{1, 12'h020, 32'hff, 32'h0, 1}, '{0, 12'h00c, 32'h0, 32'h0, 0},
             '{0, 12'h008, 32'h0, 32'h0, 0}};
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk(q, rows[i].x);
      chk({31'h0, e}, {31'h0, rows[i].e});
    end
    apb(1'b1, 12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h1);
    look(12'h008, 32'h2, 32'h2);
    apb(1'b1, 12'h004, 32'h1a);
    apb(1'b1, 12'h000, 32'h4);
    cmd(32'h4);
    look(12'h00c, 32'h3, 32'h3);
    xtal_ok <= 1'b0;
    wait_nmi;
    chk(q, 32'h188e);
    cmd(32'h10);
    look(12'h00c, 32'h6003, 32'h6003);
    cmd(32'h08);
    look(12'h00c, 32'h6003, 32'h2003);
    cmd(32'h2);
    look(12'h00c, 32'h8, 32'h0);
    chk({28'h0, nops}, 32'h4);
    xtal_ok <= 1'b1;
    cmd(32'h80);
    apb(1'b1, 12'h008, 32'h6);
    look(12'h008, 32'h1806, 32'h0);
    cmd(32'h20);
    look(12'h00c, 32'h7, 32'h4);
    look(12'h008, 32'h4, 32'h0);
    cmd(32'h40);
    look(12'h00c, 32'h7, 32'h0);
    // Fast fallback from a disarmed field, so the arming edge follows the selects
    cmd(32'h10);
    look(12'h00c, 32'h6003, 32'h6003);
    apb(1'b1, 12'h004, 32'h2a);
    apb(1'b1, 12'h000, 32'h4);
    cmd(32'h1);
    look(12'h00c, 32'h1ff3, 32'hc50);
    chk({31'h0, stopped}, 32'h1);
    chk({28'h0, nops}, 32'h4);
    wake <= 1'b1;
    @(posedge clock_i);
    wake <= 1'b0;
    @(posedge clock_i);
    chk({30'h0, stopped, div8}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      src <= 3'h1 << i;
      wait_nmi;
      chk(q & 32'h7c, 32'h4 | (32'h10 << i));
      src <= 3'h0;
      repeat (4) @(posedge clock_i);
      apb(1'b1, 12'h008, 32'h4);
    end
    apb(1'b1, 12'h004, 32'h0b);
    cmd(32'h4);
    look(12'h00c, 32'h3, 32'h0);
    look(12'h008, 32'h2, 32'h2);
    reset_i <= 1'b1;
    repeat (12) @(posedge clock_i);
    reset_i <= 1'b0;
    @(posedge clock_i);
    look(12'h00c, 32'hffffffff, 32'h0);
    look(12'h004, 32'hffffffff, 32'h0);
    give_verdict;
  end
endmodule
